// File: host_ctrl_gpio_dmem_access.sv
// host control registers, port b/c pins and coefficient memory writes
// assumes an axi4-lite master, pins from outside the clock domain
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "hcfg_params.svh"
module host_ctrl_gpio_dmem_access #(
  parameter int MEM_AW = 16,
  parameter int INIT_WAIT_CYCLES = `INIT_WAIT_MS * `CLK_KHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [7:0] input_port_a_pins,
  input wire logic [7:0] input_port_b_pins,
  input wire logic controller_select_pin,
  input wire logic power_down_pin_n,
  output logic [7:0] output_port_c_pins,
  output hcfg_pkg::func_ctrl_t func_out,
  output logic operating,
  input wire logic [15:0] coef_rd_addr,
  output logic [15:0] coef_rd_data
);
  import hcfg_pkg::*;
  localparam int DEPTH = 2 ** MEM_AW;

  if (MEM_AW < 1 || MEM_AW > 16 || INIT_WAIT_CYCLES < DEPTH)
  begin : g_bad_params
    $error("memory width or wait count unsupported");
  end

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [17:0] pin_s1;
  logic [17:0] pin_s2;
  logic [7:0] pin_a;
  logic [7:0] pin_b;
  logic mcu_sel;
  logic pdn_n;

  // two flops on every pin
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_s1 <= '0;
      pin_s2 <= '0;
    end
    else
    begin
      pin_s1 <= {power_down_pin_n, controller_select_pin,
                 input_port_b_pins, input_port_a_pins};
      pin_s2 <= pin_s1;
    end
  end

  assign pin_a = pin_s2[7:0];
  assign pin_b = pin_s2[15:8];
  assign mcu_sel = pin_s2[16];
  assign pdn_n = pin_s2[17];

  // ****************************************
  // axi4-lite slave
  // ****************************************
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [7:0] aw_addr_q, next_aw_addr_q;
  logic [7:0] w_data_q, next_w_data_q;
  logic w_lane_q, next_w_lane_q;
  logic next_bvalid, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire, rd_fire, wr_en, wr_ok, rd_ok;
  logic [7:0] rd_val;

  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid;
  assign wr_fire = aw_held && w_held && !bvalid;
  assign rd_fire = arvalid && arready;
  assign wr_en = wr_fire && w_lane_q;

  // register file fields used by the decode
  logic [7:0] ctrl0, next_ctrl0;
  logic mem_cmd, next_mem_cmd;
  logic [7:0] func_reg, next_func_reg;
  logic [7:0] vol_reg, next_vol_reg;
  logic [15:0] addr_stage, next_addr_stage;
  logic [15:0] data_stage, next_data_stage;
  logic [7:0] sel_a, next_sel_a;
  logic [7:0] sel_b, next_sel_b;
  logic [7:0] port_c, next_port_c;
  logic ready, next_ready;
  mode_t mode, next_mode;
  logic [31:0] cnt, next_cnt;

  // read decode, reserved registers read their fixed values
  always_comb
  begin
    rd_val = `RST_BYTE;
    rd_ok = 1'b1;
    if (araddr == `A_CTRL_ZERO) rd_val = ctrl0;
    else if (araddr == `A_CTRL_ONE) rd_val = {mem_cmd, 7'h00};
    else if (araddr == `A_FUNC) rd_val = func_reg;
    else if (araddr == `A_VOLUME) rd_val = vol_reg;
    else if (araddr == `A_ADDR_HI) rd_val = addr_stage[15:8];
    else if (araddr == `A_ADDR_LO) rd_val = addr_stage[7:0];
    else if (araddr == `A_DATA_HI) rd_val = data_stage[15:8];
    else if (araddr == `A_DATA_LO) rd_val = data_stage[7:0];
    else if (araddr == `A_STATUS) rd_val = {ready, 7'h00};
    else if (araddr == `A_SEL_A) rd_val = sel_a;
    else if (araddr == `A_SEL_B) rd_val = sel_b;
    else if (araddr == `A_PORT_B) rd_val = pin_b;
    else if (araddr == `A_PORT_C) rd_val = port_c;
    else if (araddr == `A_RSV_SIX) rd_val = `RST_BYTE;
    else if (araddr == `A_RSV_SEVEN) rd_val = `RST_BYTE;
    else if (araddr == `A_RSV_EIGHT) rd_val = `RST_RSV_EIGHT;
    else rd_ok = 1'b0;
  end

  // write decode, only the answer code
  always_comb
  begin
    wr_ok = 1'b1;
    if (aw_addr_q[1:0] != 2'b00) wr_ok = 1'b0;
    else if (aw_addr_q > `A_RSV_EIGHT) wr_ok = 1'b0;
  end

  // channel next state
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr_q = aw_addr_q;
    next_w_data_q = w_data_q;
    next_w_lane_q = w_lane_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr_q = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_held = 1'b1;
      next_w_data_q = wdata[7:0];
      next_w_lane_q = wstrb[0];
    end
    if (bvalid && bready) next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (rvalid && rready) next_rvalid = 1'b0;
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rdata = {24'h000000, rd_val};
      next_rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // channel registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h00000000;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr_q <= next_aw_addr_q;
      w_data_q <= next_w_data_q;
      w_lane_q <= next_w_lane_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // control, mode sequence and memory port
  // ****************************************
  logic pd_active, commit, mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [15:0] mem_wd;
  logic [7:0] b_sec, a_sec;
  func_ctrl_t next_func;
  logic [15:0] mem [DEPTH];

  // power-up contents of one coefficient word
  function automatic logic [15:0] default_word(input logic [15:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a == `CLIP_THR_LINE || a == `CLIP_THR_AC) v = `CLIP_THR_RST;
    else if (a == `DELAY_LINE) v = `DELAY_LINE_RST;
    else if (a == `DELAY_AC) v = `DELAY_AC_RST;
    return v;
  endfunction

  assign pd_active = !pdn_n || ctrl0[`BIT_SOFT_PD];
  assign commit = mem_cmd && mode != pd_wait;

  // register writes, power-down release values, mode walk
  always_comb
  begin
    next_ctrl0 = ctrl0;
    next_mem_cmd = mem_cmd;
    next_func_reg = func_reg;
    next_vol_reg = vol_reg;
    next_addr_stage = addr_stage;
    next_data_stage = data_stage;
    next_sel_a = sel_a;
    next_sel_b = sel_b;
    next_port_c = port_c;
    next_ready = ready;
    next_mode = mode;
    next_cnt = cnt;
    if (commit) next_mem_cmd = 1'b0;
    if (wr_en)
    begin
      if (aw_addr_q == `A_CTRL_ZERO) next_ctrl0 = w_data_q & `CTRL_ZERO_MASK;
      else if (aw_addr_q == `A_CTRL_ONE && mode != pd_wait)
        next_mem_cmd = next_mem_cmd | w_data_q[`BIT_MEM_WR];
      else if (aw_addr_q == `A_FUNC) next_func_reg = w_data_q;
      else if (aw_addr_q == `A_VOLUME) next_vol_reg = w_data_q;
      else if (aw_addr_q == `A_ADDR_HI) next_addr_stage[15:8] = w_data_q;
      else if (aw_addr_q == `A_ADDR_LO) next_addr_stage[7:0] = w_data_q;
      else if (aw_addr_q == `A_DATA_HI) next_data_stage[15:8] = w_data_q;
      else if (aw_addr_q == `A_DATA_LO) next_data_stage[7:0] = w_data_q;
      else if (aw_addr_q == `A_SEL_A) next_sel_a = w_data_q;
      else if (aw_addr_q == `A_SEL_B) next_sel_b = w_data_q & `SEL_B_MASK;
      else if (aw_addr_q == `A_PORT_C) next_port_c = w_data_q;
    end
    if (pd_active)
    begin
      next_ctrl0[`BIT_OP_START] = 1'b0;
      next_func_reg = `RST_BYTE;
      next_vol_reg = `RST_BYTE;
      next_mem_cmd = 1'b0;
      next_ready = 1'b0;
      next_mode = pd_wait;
      next_cnt = 32'h00000000;
    end
    else
    begin
      case (mode)
        pd_wait:
        begin
          if (cnt == 32'(INIT_WAIT_CYCLES - 1))
          begin
            next_ready = 1'b1;
            next_mode = mcu_sel ? run_mode : init_mode;
          end
          else next_cnt = cnt + 32'h00000001;
        end
        init_mode:
          if (ctrl0[`BIT_OP_START]) next_mode = run_mode;
        default:
          next_mode = run_mode;
      endcase
    end
  end

  // memory port: default sweep during the wait, then staged commits
  always_comb
  begin
    mem_we = 1'b0;
    mem_wa = addr_stage[MEM_AW-1:0];
    mem_wd = data_stage;
    if (mode == pd_wait && !pd_active && cnt < 32'(DEPTH))
    begin
      mem_we = 1'b1;
      mem_wa = cnt[MEM_AW-1:0];
      mem_wd = default_word(cnt[15:0]);
    end
    else if (commit) mem_we = 1'b1;
  end

  // function outputs, pin side gated by the select registers
  always_comb
  begin
    b_sec = pin_b & sel_b;
    a_sec = pin_a & sel_a;
    next_func.echo_line_en = func_reg[7] | b_sec[7];
    next_func.echo_acoustic_en = func_reg[6] | b_sec[7];
    next_func.echo_mode = func_reg[5] | b_sec[6];
    next_func.slope_bypass = func_reg[4] | b_sec[5];
    next_func.rx_alc_bypass = func_reg[3] | b_sec[4];
    next_func.nc_bypass = func_reg[2] | b_sec[3];
    next_func.analog_out_sel = func_reg[1] | b_sec[2];
    next_func.line_enable = func_reg[0] | b_sec[1];
    next_func.tx_volume = vol_reg[3:0] | a_sec[3:0];
    next_func.rx_volume = vol_reg[7:4] | a_sec[7:4];
  end

  // control registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl0 <= `RST_BYTE;
      mem_cmd <= 1'b0;
      func_reg <= `RST_BYTE;
      vol_reg <= `RST_BYTE;
      addr_stage <= 16'h0000;
      data_stage <= 16'h0000;
      sel_a <= `RST_BYTE;
      sel_b <= `RST_BYTE;
      port_c <= `RST_BYTE;
      ready <= 1'b0;
      mode <= pd_wait;
      cnt <= 32'h00000000;
      func_out <= '0;
      coef_rd_data <= 16'h0000;
    end
    else
    begin
      ctrl0 <= next_ctrl0;
      mem_cmd <= next_mem_cmd;
      func_reg <= next_func_reg;
      vol_reg <= next_vol_reg;
      addr_stage <= next_addr_stage;
      data_stage <= next_data_stage;
      sel_a <= next_sel_a;
      sel_b <= next_sel_b;
      port_c <= next_port_c;
      ready <= next_ready;
      mode <= next_mode;
      cnt <= next_cnt;
      func_out <= next_func;
      coef_rd_data <= mem[coef_rd_addr[MEM_AW-1:0]];
    end
  end

  // coefficient store
  always_ff @(posedge clk)
  begin
    if (mem_we) mem[mem_wa] <= mem_wd;
  end

  assign output_port_c_pins = port_c;
  assign operating = (mode == run_mode);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_port_b_read: assert property (
    rd_fire && araddr == `A_PORT_B |=> rdata[7:0] == $past(pin_b) && rdata[31:8] == 24'h0)
    else $error("port b read mismatch");
  chk_port_b_inert: assert property (
    wr_fire && aw_addr_q == `A_PORT_B && !pd_active |=> $stable(port_c) && $stable(func_reg))
    else $error("port b write had an effect");
  chk_port_c_drive: assert property (
    wr_en && aw_addr_q == `A_PORT_C |=> output_port_c_pins == $past(w_data_q))
    else $error("port c pins not driven");
  chk_port_c_read: assert property (
    rd_fire && araddr == `A_PORT_C |=> rdata[7:0] == $past(output_port_c_pins))
    else $error("port c read mismatch");
  chk_mem_commit: assert property (
    commit |-> mem_we && mem_wa == addr_stage[MEM_AW-1:0] && mem_wd == data_stage)
    else $error("commit lost");
  chk_mem_word: assert property (
    commit |=> mem[$past(addr_stage[MEM_AW-1:0])] == $past(data_stage))
    else $error("staged word not stored");
  chk_cmd_clear: assert property (
    commit && !(wr_en && aw_addr_q == `A_CTRL_ONE) |=> !mem_cmd)
    else $error("write bit not cleared");
  chk_ready_wait: assert property (
    $rose(ready) |-> $past(cnt) == 32'(INIT_WAIT_CYCLES - 1) && $past(!mcu_sel) == (mode == init_mode))
    else $error("ready at wrong time");
  chk_op_start: assert property (
    mode == init_mode && ctrl0[`BIT_OP_START] && !pd_active |=> operating)
    else $error("start bit ignored");
  chk_or_volume: assert property (
    1'b1 |=> func_out.tx_volume == ($past(vol_reg[3:0]) | ($past(pin_a[3:0]) & $past(sel_a[3:0]))))
    else $error("volume not ored");
  chk_pd_clears: assert property (
    pd_active |=> func_reg == `RST_BYTE && vol_reg == `RST_BYTE && !ctrl0[`BIT_OP_START])
    else $error("paired bits not restored");
  chk_sel_gate: assert property (
    !sel_b[1] && !func_reg[0] |=> !func_out.line_enable)
    else $error("unselected pin acted");

  cov_commit: cover property (commit ##1 !mem_cmd);
  cov_start: cover property (mode == init_mode ##1 mode == run_mode);
  cov_port_c: cover property (wr_en && aw_addr_q == `A_PORT_C);
endmodule

// File: hcfg_params.svh
// offsets, field positions, reset values and timing counts of the
// host control, port and coefficient memory block
// assumes a 32-bit register bus with one aligned word per register
`ifndef HCFG_PARAMS_SVH
`define HCFG_PARAMS_SVH
`define A_CTRL_ZERO 8'h00
`define A_CTRL_ONE 8'h04
`define A_FUNC 8'h08
`define A_VOLUME 8'h0c
`define A_ADDR_HI 8'h10
`define A_ADDR_LO 8'h14
`define A_DATA_HI 8'h18
`define A_DATA_LO 8'h1c
`define A_STATUS 8'h20
`define A_SEL_A 8'h24
`define A_SEL_B 8'h28
`define A_PORT_B 8'h2c
`define A_PORT_C 8'h30
`define A_RSV_SIX 8'h34
`define A_RSV_SEVEN 8'h38
`define A_RSV_EIGHT 8'h3c
`define BIT_SOFT_PD 7
`define BIT_OP_START 0
`define BIT_MEM_WR 7
`define BIT_READY 7
`define CTRL_ZERO_MASK 8'h81
`define SEL_B_MASK 8'hfe
`define RST_BYTE 8'h00
`define RST_RSV_EIGHT 8'hff
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define CLIP_THR_LINE 16'h07b2
`define CLIP_THR_AC 16'h07ab
`define CLIP_THR_RST 16'h0020
`define DELAY_LINE 16'h0aa4
`define DELAY_LINE_RST 16'h00a0
`define DELAY_AC 16'h0abd
`define DELAY_AC_RST 16'h0200
`define INIT_WAIT_MS 250
`define CLK_KHZ 100000
`endif

// File: hcfg_pkg.sv
// types shared by the host control block
// assumes hcfg_params.svh holds the numbers
package hcfg_pkg;
  typedef enum logic [1:0] {pd_wait, init_mode, run_mode} mode_t;
  typedef struct packed {
    logic echo_line_en;
    logic echo_acoustic_en;
    logic echo_mode;
    logic slope_bypass;
    logic rx_alc_bypass;
    logic nc_bypass;
    logic analog_out_sel;
    logic line_enable;
    logic [3:0] tx_volume;
    logic [3:0] rx_volume;
  } func_ctrl_t;
endpackage

// File: mcu_model.sv
// external controller model: axi4-lite master with register tasks
// assumes the block's bus ports are wired straight to this model
`timescale 1ns/10ps
`include "hcfg_params.svh"
module mcu_model (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // ***********************************
  // bus cycles
  // ***********************************
  // idle bus at time zero
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;

  // one write; bready sometimes late to stall the slave
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'($urandom & 1);
    r = 2'b11;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready === 1'b1)
      begin
        r = bresp;
        break;
      end
      bready <= 1'b1;
    end
    bready <= 1'b0;
  endtask

  // one read; rready sometimes late
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'($urandom & 1);
    r = 2'b11;
    d = 8'hxx;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready === 1'b1)
      begin
        d = rdata[7:0];
        r = rresp;
        break;
      end
      rready <= 1'b1;
    end
    rready <= 1'b0;
  endtask

  // full staging sequence for one coefficient word
  task automatic mem_write(input logic [15:0] a, input logic [15:0] v, output logic [7:0] st);
    logic [1:0] r;
    int n;
    wr(`A_ADDR_HI, a[15:8], r);
    wr(`A_ADDR_LO, a[7:0], r);
    wr(`A_DATA_HI, v[15:8], r);
    wr(`A_DATA_LO, v[7:0], r);
    wr(`A_CTRL_ONE, 8'h80, r);
    st = 8'h80;
    for (n = 0; n < 20 && st[7] !== 1'b0; n++) rd(`A_CTRL_ONE, st, r);
  endtask
endmodule

// File: host_ctrl_gpio_dmem_access_test.sv
// self-checking bench of the host control block
// assumes mcu_model as bus master and short simulation counts
`timescale 1ns/10ps
`include "hcfg_params.svh"
module host_ctrl_gpio_dmem_access_test;
  import hcfg_pkg::*;
  localparam int WAIT = 4200;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr, araddr, input_port_a_pins, input_port_b_pins, output_port_c_pins;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  logic controller_select_pin, power_down_pin_n, operating;
  logic [15:0] coef_rd_addr, coef_rd_data, a, v;
  logic [7:0] d, fr, vr, sa, sb;
  logic [15:0] ta[6] = '{16'h07b3, 16'h07ac, 16'h07b2, 16'h07ab, 16'h0aa4, 16'h0abd};
  logic [15:0] tv[6] = '{16'h0000, 16'h0000, 16'h0020, 16'h0020, 16'h00a0, 16'h0200};
  func_ctrl_t func_out;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0, i;

  // ***********************************
  // clock, parts and helpers
  // ***********************************
  always #5 clk = ~clk;

  host_ctrl_gpio_dmem_access #(.MEM_AW(12), .INIT_WAIT_CYCLES(WAIT)) dut_u (
    .clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .input_port_a_pins, .input_port_b_pins, .controller_select_pin, .power_down_pin_n,
    .output_port_c_pins, .func_out, .operating, .coef_rd_addr, .coef_rd_data
  );

  mcu_model mcu_u (
    .clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
  );

  // hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    comparisons++;
    if (g !== x)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic rsp_chk(input string n, input logic [1:0] x, input logic [1:0] g);
    comparisons++;
    if (g !== x)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] ad, input logic [7:0] x);
    mcu_u.rd(ad, d, r);
    chk(n, {8'h00, x}, {8'h00, d});
    rsp_chk("rresp", `RESP_OKAY, r);
  endtask

  task automatic wait_ready();
    int n;
    d = 8'h00;
    for (n = 0; n < 3000 && d[7] !== 1'b1; n++) mcu_u.rd(`A_STATUS, d, r);
  endtask

  // pin or register source per function, volumes lsb aligned
  function automatic logic [15:0] fexp(logic [7:0] f, vv, s_a, s_b, p_a, p_b);
    logic [7:0] sm, w;
    sm = {s_b[7], s_b[7:1]};
    w = vv | (p_a & s_a);
    return {f | ({p_b[7], p_b[7:1]} & sm), w[3:0], w[7:4]};
  endfunction

  task automatic end_of_test();
    if (fails == 0 && comparisons > 0)
    begin
      $display("Finished cleanly");
    end
    else
    begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ***********************************
  // main sequence
  // ***********************************
  initial
  begin
    input_port_a_pins = 8'h00;
    input_port_b_pins = 8'h00;
    controller_select_pin = 1'b0;
    power_down_pin_n = 1'b1;
    coef_rd_addr = 16'h0000;
    void'($urandom(24));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t0 = cyc;
    rchk("status", `A_STATUS, 8'h00);
    rchk("rsv six", `A_RSV_SIX, `RST_BYTE);
    rchk("rsv seven", `A_RSV_SEVEN, `RST_BYTE);
    rchk("rsv eight", `A_RSV_EIGHT, `RST_RSV_EIGHT);
    rchk("port c", `A_PORT_C, 8'h00);
    wait_ready();
    chk("ready", 16'h0001, {15'h0000, d[7]});
    chk("ready late", 16'h0001, 16'(cyc - t0 >= WAIT));
    // port b levels, writes there must not stick
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      input_port_b_pins <= (i < 2) ? {8{i[0]}} : 8'($urandom);
      repeat (4) @(posedge clk);
      mcu_u.wr(`A_PORT_B, ~input_port_b_pins, r);
      rsp_chk("bresp", `RESP_OKAY, r);
      rchk("port b", `A_PORT_B, input_port_b_pins);
    end
    // port c drive and readback
    for (i = 0; i < 8; i++)
    begin
      d = (i < 2) ? {8{i[0]}} : 8'($urandom);
      fr = d;
      mcu_u.wr(`A_PORT_C, fr, r);
      repeat (2) @(posedge clk);
      chk("pins c", {8'h00, fr}, {8'h00, output_port_c_pins});
      rchk("port c", `A_PORT_C, fr);
    end
    // coefficient defaults
    for (i = 0; i < 6; i++)
    begin
      coef_rd_addr <= ta[i];
      repeat (3) @(posedge clk);
      chk("coef default", tv[i], coef_rd_data);
    end
    // indirect writes, back to back words
    for (i = 0; i < 5; i++)
    begin
      a = (i == 0) ? 16'h0aa4 : {4'h0, 12'($urandom)};
      v = 16'($urandom);
      mcu_u.mem_write(a, v, d);
      chk("write bit", 16'h0000, {8'h00, d});
      coef_rd_addr <= a;
      repeat (3) @(posedge clk);
      chk("coef", v, coef_rd_data);
    end
    // pin and register sources ored
    for (i = 0; i < 6; i++)
    begin
      sa = 8'($urandom);
      sb = 8'($urandom) & `SEL_B_MASK;
      fr = 8'($urandom) & ~{sb[7], sb[7:1]};
      vr = 8'($urandom) & ~sa;
      mcu_u.wr(`A_SEL_A, sa, r);
      mcu_u.wr(`A_SEL_B, sb, r);
      mcu_u.wr(`A_FUNC, fr, r);
      mcu_u.wr(`A_VOLUME, vr, r);
      input_port_a_pins <= 8'($urandom);
      input_port_b_pins <= 8'($urandom);
      repeat (6) @(posedge clk);
      chk("func", fexp(fr, vr, sa, sb, input_port_a_pins, input_port_b_pins),
          func_out);
    end
    // pin power-down then soft power-down restore paired bits
    power_down_pin_n <= 1'b0;
    repeat (6) @(posedge clk);
    power_down_pin_n <= 1'b1;
    rchk("func", `A_FUNC, 8'h00);
    rchk("volume", `A_VOLUME, 8'h00);
    wait_ready();
    mcu_u.wr(`A_FUNC, 8'h5a, r);
    mcu_u.wr(`A_VOLUME, 8'ha5, r);
    mcu_u.wr(`A_CTRL_ZERO, 8'h80, r);
    mcu_u.wr(`A_CTRL_ZERO, 8'h00, r);
    rchk("func", `A_FUNC, 8'h00);
    rchk("volume", `A_VOLUME, 8'h00);
    wait_ready();
    chk("ready", 16'h0001, {15'h0000, d[7]});
    // leave initial mode
    chk("operating", 16'h0000, {15'h0000, operating});
    mcu_u.wr(`A_CTRL_ZERO, 8'h01, r);
    repeat (3) @(posedge clk);
    chk("operating", 16'h0001, {15'h0000, operating});
    // unmapped and unaligned places
    for (i = 0; i < 2; i++)
    begin
      d = (i == 0) ? 8'h40 : 8'h01;
      mcu_u.wr(d, 8'hff, r);
      rsp_chk("bresp bad", `RESP_SLVERR, r);
      mcu_u.rd(d, fr, r);
      rsp_chk("rresp bad", `RESP_SLVERR, r);
    end
    // controller select high goes straight to normal operation
    controller_select_pin <= 1'b1;
    mcu_u.wr(`A_CTRL_ZERO, 8'h80, r);
    mcu_u.wr(`A_CTRL_ZERO, 8'h00, r);
    wait_ready();
    chk("ready sel", 16'h0001, {15'h0000, d[7]});
    chk("operating sel", 16'h0001, {15'h0000, operating});
    end_of_test();
  end
endmodule
